// file: cgt_pkg.sv
// Constants and types for the counter gate timing generator
// Summary of operation
// R1: Direct range gate width 1 us to 1 s, set by resolution 1 MHz to 1 Hz.
// R2: Microwave range gives one 10 us gate at 1 MHz, one 1 s gate at 1 Hz.
// R3: Microwave 100 kHz to 10 Hz: four equal sub-gates, 100 us dead time apart.
// R4: Sequence generator runs on the 1 MHz time base; no time base stops it.
// R5: Low clear pulse resets all shift register stages to zero.
// R6: After clear, one shifted in, taps rise on shift clocks 1, 3, 15 and 20.
// R7: Load presets the sequence counter; terminal output pulses on the 14th clock.
// R8: Only the first time-base period forms the direct gate; later ones ignored.
// R9: Status read drives gate over on D4, sequence end D1, run-down end D2.
// R10: Sequence run lasts 360 ms normally, 2.096 s in FM mode.
// R11: Local oscillator select toggles pseudo-randomly during the sequence run.
// R12: Gate outputs active low, widths counted in 1 MHz time-base cycles.
package cgt_pkg;
	localparam int unsigned TB_HZ = 1000000;
	localparam int unsigned US_PER_S = 1000000;
	// Dead time between microwave sub-gates
	localparam int unsigned DEAD_US = 100;
	localparam int unsigned DEAD_TICKS = DEAD_US * TB_HZ / US_PER_S;
	localparam int unsigned SUBGATES = 4;
	// Sequence run lengths
	localparam int unsigned RUN_NORM_MS = 360;
	localparam int unsigned RUN_FM_US = 2096000;
	localparam int unsigned RUN_NORM_TICKS = RUN_NORM_MS * (TB_HZ / 1000);
	localparam int unsigned RUN_FM_TICKS = RUN_FM_US / (US_PER_S / TB_HZ);
	// Shift register: three packages of eight stages
	localparam int unsigned SR_LEN = 24;
	localparam int unsigned TAP0 = 0;
	localparam int unsigned TAP1 = 2;
	localparam int unsigned TAP2 = 14;
	localparam int unsigned TAP3 = 19;
	// Sequence counter preset gives terminal on 14th clock
	localparam logic [7:0] CNT_TERM = 8'hFF;
	localparam logic [7:0] CNT_PRESET = 8'hF1;
	// Status bus bit positions
	localparam int unsigned ST_SEQ_END = 1;
	localparam int unsigned ST_RUNDOWN_END = 2;
	localparam int unsigned ST_GATE_OVER = 4;
	localparam int unsigned CNT_W = 22;
	typedef enum logic [1:0] {
		CGT_IDLE = 2'b00,
		CGT_OPEN = 2'b01,
		CGT_DEAD = 2'b10,
		CGT_OVER = 2'b11
	} cgt_gate_t;
	// Gate width in time-base ticks: res 0 = 1 MHz ... 6 = 1 Hz
	function automatic logic [CNT_W-1:0] cgt_width(input logic [2:0] res, input logic mw);
		logic [CNT_W-1:0] w;
		w = 22'h000001;
		for (int i = 0; i < 6; i++) begin
			if (i < int'(res)) begin
				w = CNT_W'(w * 10);
			end
		end
		if (mw && res == 3'h0) begin
			w = 22'h00000A;
		end
		return w;
	endfunction
endpackage

// file: cgt_timing_gen.sv
// Gate and pseudo-random sequence timing generator
`timescale 1ns/1ps
module cgt_timing_gen #(
	parameter int unsigned RUN_NORM = cgt_pkg::RUN_NORM_TICKS,
	parameter int unsigned RUN_FM = cgt_pkg::RUN_FM_TICKS
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Time base
	input wire logic tb_tick_i,
	// Measurement control
	input wire logic start_i,
	input wire logic microwave_i,
	input wire logic [2:0] resolution_i,
	input wire logic fm_mode_i,
	input wire logic seq_start_i,
	input wire logic rundown_done_i,
	// Sequence generator test access
	input wire logic sr_clear_n_i,
	input wire logic sr_data_i,
	input wire logic cnt_load_i,
	// Gate and sequence generator outputs
	output logic direct_count_gate_n_o,
	output logic if_count_gate_n_o,
	output logic local_osc_select_o,
	output logic sequence_active_point_o,
	output logic [3:0] sr_taps_o,
	output logic cnt_terminal_o,
	// Status read
	input wire logic status_rd_i,
	output logic [7:0] status_data_o
);
	// Reset release synchroniser
	logic rs1_q, rst_q;
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rs1_q <= 1'b0;
			rst_q <= 1'b0;
		end else begin
			rs1_q <= 1'b1;
			rst_q <= rs1_q;
		end
	end

	// Gate state
	cgt_pkg::cgt_gate_t st_q, st_d;
	logic [cgt_pkg::CNT_W-1:0] cnt_q, cnt_d;
	logic [1:0] sub_q, sub_d;
	logic mw_q, mw_d, split_q, split_d;
	logic dg_n_q, dg_n_d, ig_n_q, ig_n_d;
	logic [cgt_pkg::CNT_W-1:0] wid_q, wid_d;

	// Last tick of a down count
	function automatic logic cnt_last(input logic [cgt_pkg::CNT_W-1:0] c);
		return c <= cgt_pkg::CNT_W'(1);
	endfunction

	// Sub-gates only between the single-gate end points
	function automatic logic split_sel(input logic [2:0] res, input logic mw);
		return mw && res != 3'h0 && res < 3'h6;
	endfunction

	// Next state and gate levels
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		sub_d = sub_q;
		mw_d = mw_q;
		split_d = split_q;
		wid_d = wid_q;
		case (st_q)
			cgt_pkg::CGT_IDLE, cgt_pkg::CGT_OVER: begin
				if (start_i) begin
					st_d = cgt_pkg::CGT_OPEN;
					mw_d = microwave_i;
					split_d = split_sel(resolution_i, microwave_i); // R3
					sub_d = 2'h0;
					wid_d = cgt_pkg::cgt_width(resolution_i, microwave_i); // R1 R2
					cnt_d = wid_d;
				end
			end
			cgt_pkg::CGT_OPEN: begin
				if (tb_tick_i) begin // R12
					if (!cnt_last(cnt_q)) begin
						cnt_d = cnt_q - 22'h000001;
					end else if (split_q && sub_q != 2'(cgt_pkg::SUBGATES - 1)) begin
						st_d = cgt_pkg::CGT_DEAD; // R3
						cnt_d = cgt_pkg::CNT_W'(cgt_pkg::DEAD_TICKS);
					end else begin
						st_d = cgt_pkg::CGT_OVER; // R8
					end
				end
			end
			cgt_pkg::CGT_DEAD: begin
				if (tb_tick_i) begin
					if (!cnt_last(cnt_q)) begin
						cnt_d = cnt_q - 22'h000001;
					end else begin
						st_d = cgt_pkg::CGT_OPEN;
						sub_d = sub_q + 2'h1;
						cnt_d = wid_q;
					end
				end
			end
			default: st_d = cgt_pkg::CGT_IDLE;
		endcase
		dg_n_d = !(st_d == cgt_pkg::CGT_OPEN && !mw_d); // R12
		ig_n_d = !(st_d == cgt_pkg::CGT_OPEN && mw_d);
	end

	always_ff @(posedge mclk_i or negedge rst_q) begin
		if (!rst_q) begin
			st_q <= cgt_pkg::CGT_IDLE;
			cnt_q <= '0;
			sub_q <= 2'h0;
			mw_q <= 1'b0;
			split_q <= 1'b0;
			dg_n_q <= 1'b1;
			ig_n_q <= 1'b1;
			wid_q <= '0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			sub_q <= sub_d;
			mw_q <= mw_d;
			split_q <= split_d;
			dg_n_q <= dg_n_d;
			ig_n_q <= ig_n_d;
			wid_q <= wid_d;
		end
	end

	// Sequence generator state
	logic [cgt_pkg::SR_LEN-1:0] sr_q, sr_d;
	logic [7:0] sc_q, sc_d;
	logic term_q, term_d;
	logic [cgt_pkg::CNT_W-1:0] run_q, run_d;
	logic act_q, act_d, lo_q, lo_d, seqend_q, seqend_d;
	logic fb;

	// Shift, count and run down
	always_comb begin
		sr_d = sr_q;
		sc_d = sc_q;
		term_d = 1'b0;
		run_d = run_q;
		act_d = act_q;
		lo_d = lo_q;
		seqend_d = seqend_q;
		fb = sr_q[cgt_pkg::TAP3] ^ sr_q[cgt_pkg::TAP2] ^ sr_q[cgt_pkg::TAP1] ^ sr_q[cgt_pkg::TAP0];
		if (!sr_clear_n_i) begin
			sr_d = '0; // R5
		end else if (tb_tick_i) begin // R4
			sr_d = {sr_q[cgt_pkg::SR_LEN-2:0], act_q ? (fb | ~|sr_q) : sr_data_i}; // R6
		end
		if (cnt_load_i) begin
			sc_d = cgt_pkg::CNT_PRESET; // R7
		end else if (tb_tick_i) begin
			sc_d = sc_q + 8'h01;
			term_d = sc_q == cgt_pkg::CNT_TERM - 8'h01; // R7
		end
		if (seq_start_i && !act_q) begin
			act_d = 1'b1;
			seqend_d = 1'b0;
			run_d = cgt_pkg::CNT_W'(fm_mode_i ? RUN_FM : RUN_NORM); // R10
		end else if (act_q && tb_tick_i) begin
			lo_d = sr_q[cgt_pkg::TAP3]; // R11
			if (!cnt_last(run_q)) begin
				run_d = run_q - 22'h000001;
			end else begin
				act_d = 1'b0;
				seqend_d = 1'b1;
				lo_d = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_i or negedge rst_q) begin
		if (!rst_q) begin
			sr_q <= '0;
			sc_q <= 8'h00;
			term_q <= 1'b0;
			run_q <= '0;
			act_q <= 1'b0;
			lo_q <= 1'b1;
			seqend_q <= 1'b0;
		end else begin
			sr_q <= sr_d;
			sc_q <= sc_d;
			term_q <= term_d;
			run_q <= run_d;
			act_q <= act_d;
			lo_q <= lo_d;
			seqend_q <= seqend_d;
		end
	end

	// Status read port
	logic [7:0] stat_q, stat_d;
	// Status byte only while strobed, else zero
	always_comb begin
		stat_d = 8'h00;
		if (status_rd_i) begin
			stat_d[cgt_pkg::ST_GATE_OVER] = st_q == cgt_pkg::CGT_OVER; // R9
			stat_d[cgt_pkg::ST_SEQ_END] = seqend_q;
			stat_d[cgt_pkg::ST_RUNDOWN_END] = rundown_done_i;
		end
	end

	always_ff @(posedge mclk_i or negedge rst_q) begin
		if (!rst_q) begin
			stat_q <= 8'h00;
		end else begin
			stat_q <= stat_d;
		end
	end

	// Registered outputs
	assign direct_count_gate_n_o = dg_n_q;
	assign if_count_gate_n_o = ig_n_q;
	assign local_osc_select_o = lo_q;
	assign sequence_active_point_o = act_q;
	assign sr_taps_o = {sr_q[cgt_pkg::TAP3], sr_q[cgt_pkg::TAP2], sr_q[cgt_pkg::TAP1], sr_q[cgt_pkg::TAP0]};
	assign cnt_terminal_o = term_q;
	assign status_data_o = stat_q;
endmodule // cgt_timing_gen

// file: cgt_timing_gen_checker.sv
// Port assertions for the timing generator
`timescale 1ns/1ps
module cgt_timing_gen_checker (
	input logic mclk_i,
	input logic rst_n_i,
	input logic tb_tick_i,
	input logic start_i,
	input logic microwave_i,
	input logic seq_start_i,
	input logic rundown_done_i,
	input logic sr_clear_n_i,
	input logic status_rd_i,
	input logic direct_count_gate_n_o,
	input logic if_count_gate_n_o,
	input logic local_osc_select_o,
	input logic sequence_active_point_o,
	input logic [3:0] sr_taps_o,
	input logic cnt_terminal_o,
	input logic [7:0] status_data_o
);
	default clocking @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);
	sequence rd_s;
		status_rd_i && rundown_done_i;
	endsequence
	sequence tick_s;
		$past(tb_tick_i) || $past(tb_tick_i, 2);
	endsequence
	dir_open_a: assert property ($fell(direct_count_gate_n_o) |-> ($past(start_i) || $past(start_i, 2)) && !microwave_i)
		else $error("bad direct open");
	if_open_a: assert property ($fell(if_count_gate_n_o) |-> tick_s or ($past(start_i) || $past(start_i, 2)))
		else $error("bad if open");
	rd_idle_a: assert property (!status_rd_i |=> status_data_o == 8'h00)
		else $error("status not idle");
	rundown_a: assert property (rd_s |=> status_data_o[2])
		else $error("rundown bit lost");
	lo_idle_a: assert property (!sequence_active_point_o [*2] |-> local_osc_select_o)
		else $error("select not idle");
	seq_go_a: assert property (seq_start_i && !sequence_active_point_o |=> sequence_active_point_o)
		else $error("run not started");
	term_a: assert property (cnt_terminal_o |-> tick_s ##1 !cnt_terminal_o)
		else $error("bad terminal");
	clear_a: assert property (!sr_clear_n_i [*2] |=> sr_taps_o == 4'h0)
		else $error("clear failed");
endmodule // cgt_timing_gen_checker
bind cgt_timing_gen cgt_timing_gen_checker cgt_timing_gen_checker_i (.*);

// file: cgt_cpu_model.sv
// Processor model reading the status word
`timescale 1ns/1ps
module cgt_cpu_model (
	input logic mclk_i,
	input logic [7:0] status_data_i,
	output logic status_rd_o
);
	initial status_rd_o = 1'b0;
	// Strobe held over the answer edge
	task automatic read(output logic [7:0] d);
		@(posedge mclk_i) #1 status_rd_o = 1'b1;
		repeat (2) @(posedge mclk_i);
		d = status_data_i;
		#1 status_rd_o = 1'b0;
	endtask
endmodule // cgt_cpu_model

// file: tb_cgt_timing_gen.sv
// Self-checking bench for the timing generator
`timescale 1ns/1ps
module tb_cgt_timing_gen;
	logic mclk_i = 1'b0, rst_n_i = 1'b0, tb_tick_i = 1'b0, start_i = 1'b0, microwave_i = 1'b0, fm_mode_i = 1'b0;
	logic seq_start_i = 1'b0, rundown_done_i = 1'b0, sr_clear_n_i = 1'b1, sr_data_i = 1'b1, cnt_load_i = 1'b0;
	logic status_rd_i, direct_count_gate_n_o, if_count_gate_n_o, local_osc_select_o, sequence_active_point_o;
	logic cnt_terminal_o;
	logic [2:0] resolution_i = 3'h0;
	logic [3:0] sr_taps_o;
	logic [7:0] status_data_o, d;
	int fails = 0, checked = 0, n, m = 0, tk_n = 0, term_at = 0, lo_hits = 0;
	wire logic [2:0] mon = {sequence_active_point_o, if_count_gate_n_o, direct_count_gate_n_o};
	always #2 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		if (sequence_active_point_o === 1'b1 && local_osc_select_o === 1'b0) lo_hits <= lo_hits + 1;
		if (cnt_terminal_o === 1'b1) term_at <= tk_n;
	end
	cgt_timing_gen #(.RUN_NORM(50), .RUN_FM(80)) cgt_timing_gen_i (.*);
	cgt_cpu_model cgt_cpu_model_i (.mclk_i, .status_data_i(status_data_o), .status_rd_o(status_rd_i));
	task automatic results();
		if (fails == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t got %0h exp %0h", $time, got, exp);
		end
	endtask
	task automatic tk();
		@(posedge mclk_i) #1 tb_tick_i = 1'b1;
		@(posedge mclk_i) #1 tb_tick_i = 1'b0;
		tk_n++;
		repeat (2) @(posedge mclk_i);
	endtask
	task automatic pulse(ref logic s);
		@(posedge mclk_i) #1 s = 1'b1;
		@(posedge mclk_i) #1 s = 1'b0;
	endtask
	task automatic span(input int k, input logic lvl, output int c);
		c = 0;
		@(posedge mclk_i) #1;
		while (mon[k] === lvl) begin
			tk();
			c++;
			if (c > 400) begin
				fails++;
				results();
			end
		end
	endtask
	task automatic clr();
		@(posedge mclk_i) #1 sr_clear_n_i = 1'b0;
		repeat (2) @(posedge mclk_i);
		#1 sr_clear_n_i = 1'b1;
	endtask
	task automatic t_direct();
		for (int r = 0; r < 3; r++) begin
			#1 resolution_i = 3'(r);
			pulse(start_i);
			span(0, 1'b0, n);
			chk(n, 10 ** r);
		end
		repeat (3) tk();
		chk(direct_count_gate_n_o, 1'b1);
		cgt_cpu_model_i.read(d);
		chk(d, 8'h10);
	endtask
	task automatic t_micro();
		@(posedge mclk_i) #1 microwave_i = 1'b1;
		resolution_i = 3'h0;
		pulse(start_i);
		span(1, 1'b0, n);
		chk(n, 10);
		#1 resolution_i = 3'h1;
		pulse(start_i);
		for (int i = 0; i < 4; i++) begin
			span(1, 1'b0, n);
			chk(n, 10);
			if (i < 3) span(1, 1'b1, n);
			if (i < 3) chk(n, 100);
		end
	endtask
	task automatic t_sr();
		clr();
		repeat (9) @(posedge mclk_i);
		chk(sr_taps_o, 4'h0);
		for (int t = 1; t <= 20; t++) begin
			tk();
			chk(sr_taps_o, {t >= 20, t >= 15, t >= 3, t >= 1});
		end
	endtask
	task automatic t_cnt();
		pulse(cnt_load_i);
		tk_n = 0;
		repeat (16) tk();
		chk(term_at, 14);
	endtask
	task automatic t_seq();
		for (int f = 0; f < 2; f++) begin
			clr();
			fm_mode_i = f[0];
			rundown_done_i = f[0];
			m = lo_hits;
			pulse(seq_start_i);
			span(2, 1'b1, n);
			chk(n, f ? 80 : 50);
			chk(lo_hits > m, 1'b1);
			cgt_cpu_model_i.read(d);
			chk(d, {5'h02, f[0], 2'h2});
		end
	endtask
	initial begin
		repeat (5) @(posedge mclk_i);
		#1 rst_n_i = 1'b1;
		repeat (3) @(posedge mclk_i);
		t_direct();
		t_micro();
		t_sr();
		t_cnt();
		t_seq();
		results();
	end
endmodule // tb_cgt_timing_gen
